// *** rtl/isc_i2c_status_clksel.sv ***
// i2c status flags, transfer clock select and apb register file
// =====================================================
// Notes on behaviour
// R1: wait release clears transmit state, frees data
// R2: ack flag set on low data at ninth
// R3: ack clears: stop, next first clock, release, disable
// R4: start flag set on start condition
// R5: start clears: stop, data byte clock, release, disable
// R6: stop flag set on stop condition
// R7: stop clears on next address first clock, disable
// R8: clock select register resets to zero
// R9: clock line level readable only while enabled
// R10: data line level readable only while enabled
// R11: mode bit picks standard or high speed
// R12: noise filter works only in high speed
// R13: filter never changes transfer clock rate
// R14: line level bits ignore writes
// R15: software writes zero to top two bits
// R16: divisor from mode, select and expansion bits
// R17: whole byte and single bit writes accepted
// R18: standard mode select zero divides by 44
// R19: bus lines synchronised before any use
`timescale 1ns/100ps
`default_nettype none
module isc_i2c_status_clksel (
	input  wire logic        mclk_in,
	input  wire logic        arst_n_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [31:0] pwdata_in,
	input  wire logic [3:0]  pstrb_in,
	output var  logic [31:0] prdata_out,
	output var  logic        pready_out,
	output var  logic        pslverr_out,
	input  wire logic        scl_in,
	output var  logic        scl_out,
	output var  logic        scl_oe_out,
	input  wire logic        sda_in,
	output var  logic        sda_out,
	output var  logic        sda_oe_out,
	input  wire logic        timer_tick_in,
	output var  logic        sel_tick_out,
	output var  logic        hs_mode_out,
	output var  logic        irq_out
);
	import isc_pkg::*;

	logic        hit;
	logic [31:0] rdata;
	logic        access;
	logic        wr;
	logic        wr_ctrl;
	logic        module_en;
	logic        data_low;
	logic        lrel_wr;
	logic        wrel_wr;
	logic        txreq_wr;
	logic        en_fall;
	logic        en_keep;
	logic        scl_f;
	logic        sda_f;
	logic        scl_q;
	logic        sda_q;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_det;
	logic        stop_det;
	logic [3:0]  bit_cnt;
	logic        in_frame;
	logic        first_byte;
	logic        first_clk;
	logic        ninth_rise;
	logic        wait_hold;
	logic        trc;
	logic        ack;
	logic        std;
	logic        spd;
	logic        spd_armed;
	logic        ack_set;
	logic        cld;
	logic        dad;
	logic        smc;
	logic        dfc;
	logic [1:0]  cs;
	logic        clx;
	logic [1:0]  cexp;
	logic [7:0]  div_m;
	logic        div_ok;
	logic        use_timer;
	logic        step;
	logic [7:0]  div_cnt;
	logic        tick_int;
	logic [2:0]  irq_stat;
	logic [2:0]  irq_mask;
	logic [2:0]  irq_ev;
	logic [7:0]  tick_gap;
	logic        cfg_hold;
	logic        cfg44;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);

	// =====================================================
	// apb slave: one wait state, registered answer
	assign access  = psel_in && penable_in && pready_out;
	assign wr      = access && pwrite_in && pstrb_in[0];
	assign wr_ctrl = wr && (paddr_in == ADDR_CTRL);
	assign lrel_wr  = wr_ctrl && pwdata_in[CTRL_LREL];
	assign wrel_wr  = wr_ctrl && pwdata_in[CTRL_WREL];
	assign txreq_wr = wr_ctrl && pwdata_in[CTRL_TXREQ];
	assign en_fall  = wr_ctrl && module_en && !pwdata_in[CTRL_EN];
	assign en_keep  = module_en && !en_fall;

	// read mux and address decode
	always_comb begin
		hit   = 1'b1;
		rdata = 32'h0;
		case (paddr_in)
			ADDR_CTRL: begin
				rdata[CTRL_EN]       = module_en;
				rdata[CTRL_DATA_LOW] = data_low;
			end
			ADDR_STATUS: begin
				rdata[ST_TRC] = trc;
				rdata[ST_ACK] = ack;
				rdata[ST_STD] = std;
				rdata[ST_SPD] = spd;
			end
			ADDR_CLKSEL, ADDR_CLKSEL_SET, ADDR_CLKSEL_CLR: begin
				rdata[CS_CLD]         = cld;
				rdata[CS_DAD]         = dad;
				rdata[CS_SMC]         = smc;
				rdata[CS_DFC]         = dfc;
				rdata[CS_CL1:CS_CL0] = cs;
			end
			ADDR_FEXP:     rdata[FEXP_CLX] = clx;
			ADDR_CEXP:     rdata[CEXP_HI:CEXP_LO] = cexp;
			ADDR_IRQ_STAT: rdata[IRQ_W-1:0] = irq_stat;
			ADDR_IRQ_MASK: rdata[IRQ_W-1:0] = irq_mask;
			default:       hit = 1'b0;
		endcase
	end

	// answer phase registers
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pready_out  <= 1'b0;
			prdata_out  <= 32'h0;
			pslverr_out <= 1'b0;
		end else begin
			pready_out  <= psel_in && penable_in && !pready_out;
			pslverr_out <= psel_in && penable_in && !pready_out && !hit;
			if (psel_in && penable_in && !pready_out)
				prdata_out <= hit ? rdata : 32'h0;
		end
	end

	// =====================================================
	// control register: enable and data drive level stored, others pulse
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			module_en <= 1'b0;
			data_low  <= 1'b0;
		end else if (wr_ctrl) begin
			module_en <= pwdata_in[CTRL_EN];
			data_low  <= pwdata_in[CTRL_DATA_LOW];
		end
	end

	// =====================================================
	// line conditioning, noise filter only in high speed mode
	isc_line_filter u_filter (
		.mclk_in    (mclk_in),
		.arst_n_in  (arst_n_in),
		.filt_en_in (smc && dfc), // R12
		.scl_raw_in (scl_in), // R19
		.sda_raw_in (sda_in),
		.scl_out    (scl_f),
		.sda_out    (sda_f)
	);

	// previous conditioned levels for edge detection
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_f;
			sda_q <= sda_f;
		end
	end

	assign scl_rise  = en_keep && scl_f && !scl_q;
	assign scl_fall  = en_keep && !scl_f && scl_q;
	assign start_det = en_keep && scl_f && scl_q && sda_q && !sda_f;
	assign stop_det  = en_keep && scl_f && scl_q && !sda_q && sda_f;
	assign first_clk  = scl_rise && in_frame && (bit_cnt == BIT_IDLE || bit_cnt == BIT_NINTH);
	assign ninth_rise = scl_rise && in_frame && (bit_cnt == BIT_EIGHT);
	assign ack_set    = ninth_rise && !sda_f;

	// byte tracker: clock count within byte, address byte marker
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			bit_cnt    <= BIT_IDLE;
			in_frame   <= 1'b0;
			first_byte <= 1'b0;
		end else if (!en_keep || stop_det) begin
			bit_cnt    <= BIT_IDLE;
			in_frame   <= 1'b0;
			first_byte <= 1'b0;
		end else if (start_det) begin
			bit_cnt    <= BIT_IDLE;
			in_frame   <= 1'b1;
			first_byte <= 1'b1;
		end else if (first_clk) begin
			bit_cnt <= 4'h1;
		end else if (scl_rise && in_frame) begin
			bit_cnt <= bit_cnt + 4'h1;
			if (ninth_rise)
				first_byte <= 1'b0;
		end
	end

	// =====================================================
	// wait after ninth clock, transmit state and line drives
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wait_hold <= 1'b0;
		end else if (!en_keep || wrel_wr || lrel_wr) begin
			wait_hold <= 1'b0;
		end else if (scl_fall && in_frame && bit_cnt == BIT_NINTH) begin
			wait_hold <= 1'b1;
		end
	end

	// transmit state: software request sets, release or end clears
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			trc <= 1'b0;
		end else begin
			if ((wrel_wr && wait_hold) || lrel_wr || stop_det || en_fall)
				trc <= 1'b0; // R1
			if (txreq_wr && en_keep)
				trc <= 1'b1;
		end
	end

	// open-drain drives, data line floats unless transmitting with data_low set
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			scl_out    <= 1'b0;
			sda_out    <= 1'b0;
			scl_oe_out <= 1'b0;
			sda_oe_out <= 1'b0;
		end else begin
			scl_oe_out <= wait_hold && en_keep;
			sda_oe_out <= trc && data_low && en_keep; // R1
		end
	end

	// =====================================================
	// status flags, clears first then sets
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ack <= 1'b0;
		end else begin
			if (stop_det || first_clk || lrel_wr || en_fall)
				ack <= 1'b0; // R3
			if (ack_set)
				ack <= 1'b1; // R2
		end
	end

	// start detected flag
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			std <= 1'b0;
		end else begin
			if (stop_det || (first_clk && !first_byte) || lrel_wr || en_fall)
				std <= 1'b0; // R5
			if (start_det)
				std <= 1'b1; // R4
		end
	end

	// stop detected flag, armed by a start seen while set
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			spd       <= 1'b0;
			spd_armed <= 1'b0;
		end else begin
			if ((first_clk && first_byte && spd_armed) || en_fall) begin
				spd       <= 1'b0; // R7
				spd_armed <= 1'b0;
			end else if (start_det && spd) begin
				spd_armed <= 1'b1;
			end
			if (stop_det) begin
				spd       <= 1'b1; // R6
				spd_armed <= 1'b0;
			end
		end
	end

	// =====================================================
	// line level readback, zero while disabled
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cld <= 1'b0;
			dad <= 1'b0;
		end else begin
			cld <= en_keep && scl_f; // R9
			dad <= en_keep && sda_f; // R10
		end
	end

	// clock select: byte write, set alias and clear alias
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			{smc, dfc, cs} <= CLKSEL_RST; // R8
		end else if (wr && paddr_in == ADDR_CLKSEL) begin
			{smc, dfc, cs} <= pwdata_in[CS_SMC:CS_CL0]; // R14
		end else if (wr && paddr_in == ADDR_CLKSEL_SET) begin
			{smc, dfc, cs} <= {smc, dfc, cs} | pwdata_in[CS_SMC:CS_CL0]; // R17
		end else if (wr && paddr_in == ADDR_CLKSEL_CLR) begin
			{smc, dfc, cs} <= {smc, dfc, cs} & ~pwdata_in[CS_SMC:CS_CL0]; // R17
		end
	end

	// expansion bits
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			clx  <= 1'b0;
			cexp <= 2'h0;
		end else begin
			if (wr && paddr_in == ADDR_FEXP)
				clx <= pwdata_in[FEXP_CLX];
			if (wr && paddr_in == ADDR_CEXP)
				cexp <= pwdata_in[CEXP_HI:CEXP_LO];
		end
	end

	// =====================================================
	// divisor selection; filter bit deliberately not an input here
	always_comb begin // R13
		div_m     = DIV_44;
		div_ok    = 1'b1;
		use_timer = 1'b0;
		if (clx) begin
			div_m  = DIV_12;
			div_ok = smc && !cs[1];
		end else if (smc) begin // R11
			case (cs)
				2'h0, 2'h1: div_m = DIV_24;
				2'h2:       div_m = DIV_48;
				default: begin
					case (cexp)
						2'h1:    div_m = DIV_36;
						2'h2:    div_m = DIV_54;
						2'h0: begin
							div_m     = DIV_T18;
							use_timer = 1'b1;
						end
						default: div_ok = 1'b0;
					endcase
				end
			endcase
		end else begin
			case (cs)
				2'h0:    div_m = DIV_44; // R18
				2'h1:    div_m = DIV_86;
				2'h2:    div_m = DIV_172;
				default: begin
					case (cexp)
						2'h1:    div_m = DIV_132;
						2'h2:    div_m = DIV_198;
						2'h0: begin
							div_m     = DIV_T66;
							use_timer = 1'b1;
						end
						default: div_ok = 1'b0;
					endcase
				end
			endcase
		end
	end

	assign step     = use_timer ? timer_tick_in : 1'b1;
	assign tick_int = div_ok && step && (div_cnt >= div_m - 8'h01);

	// selection clock divider, one-cycle enable per period
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			div_cnt <= 8'h00;
		end else if (!div_ok || tick_int) begin
			div_cnt <= 8'h00; // R16
		end else if (step) begin
			div_cnt <= div_cnt + 8'h01;
		end
	end

	// registered mode and selection clock outputs
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sel_tick_out <= 1'b0;
			hs_mode_out  <= 1'b0;
		end else begin
			sel_tick_out <= tick_int;
			hs_mode_out  <= smc; // R11
		end
	end

	// =====================================================
	// interrupts: sticky on flag set, write one to clear, set wins
	assign irq_ev = {ack_set, start_det, stop_det};

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			irq_stat <= 3'h0;
			irq_mask <= 3'h0;
			irq_out  <= 1'b0;
		end else begin
			if (wr && paddr_in == ADDR_IRQ_STAT)
				irq_stat <= (irq_stat & ~pwdata_in[IRQ_W-1:0]) | irq_ev;
			else
				irq_stat <= irq_stat | irq_ev;
			if (wr && paddr_in == ADDR_IRQ_MASK)
				irq_mask <= pwdata_in[IRQ_W-1:0];
			irq_out <= |(irq_stat & irq_mask);
		end
	end

	// =====================================================
	// checks
	assign cfg44 = !clx && !smc && cs == 2'h0;

	// helper: cycles since last tick, config untouched since then
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tick_gap <= 8'h00;
			cfg_hold <= 1'b0;
		end else begin
			tick_gap <= tick_int ? 8'h00 : tick_gap + 8'h01;
			if (tick_int)
				cfg_hold <= 1'b1;
			else if (wr)
				cfg_hold <= 1'b0;
		end
	end

	a_div_44: assert property (tick_int && cfg44 && cfg_hold |-> tick_gap == 8'h2B) // R18
		else $error("standard divisor period is not 44");
	a_ack_set: assert property (ack_set |=> ack && irq_stat[IRQ_ACK]) // R2
		else $error("ack flag not set at ninth clock");
	a_ack_clear: assert property (lrel_wr && !ack_set |=> !ack) // R3
		else $error("ack flag survived bus release");
	a_start_set: assert property (start_det |=> std ##1 (std || $past(stop_det || first_clk || lrel_wr))) // R4
		else $error("start flag not set");
	a_start_clear: assert property ($fell(module_en) |-> !std && !ack) // R5
		else $error("start flag survived disable");
	a_stop_set: assert property (stop_det |=> spd && !std) // R6
		else $error("stop flag not set");
	a_stop_clear: assert property (en_fall |=> !spd && !spd_armed) // R7
		else $error("stop flag survived disable");
	a_clk_level: assert property (!module_en |=> !cld) // R9
		else $error("clock level visible while disabled");
	a_data_level: assert property (module_en && $past(module_en) |-> dad == $past(sda_f)) // R10
		else $error("data level readback wrong");
	a_wait_rel: assert property (wrel_wr && wait_hold && !txreq_wr |=> !trc ##1 !sda_oe_out) // R1
		else $error("transmit state kept after wait release");
endmodule
`default_nettype wire

// *** rtl/isc_pkg.sv ***
// constants of the i2c status flags and transfer clock select block
package isc_pkg;
	// =====================================================
	// register byte offsets on the apb slave
	localparam logic [7:0] ADDR_CTRL       = 8'h00;
	localparam logic [7:0] ADDR_STATUS     = 8'h04;
	localparam logic [7:0] ADDR_CLKSEL     = 8'h08;
	localparam logic [7:0] ADDR_FEXP       = 8'h0C;
	localparam logic [7:0] ADDR_CEXP       = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STAT   = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK   = 8'h18;
	localparam logic [7:0] ADDR_CLKSEL_SET = 8'h1C;
	localparam logic [7:0] ADDR_CLKSEL_CLR = 8'h20;

	// =====================================================
	// bus_control_reg fields
	localparam int CTRL_EN       = 7;
	localparam int CTRL_LREL     = 6;
	localparam int CTRL_WREL     = 5;
	localparam int CTRL_TXREQ    = 3;
	localparam int CTRL_DATA_LOW = 0;

	// bus_status_reg fields
	localparam int ST_TRC = 3;
	localparam int ST_ACK = 2;
	localparam int ST_STD = 1;
	localparam int ST_SPD = 0;

	// transfer_clock_select_reg fields and reset value
	localparam int         CS_CLD     = 5;
	localparam int         CS_DAD     = 4;
	localparam int         CS_SMC     = 3;
	localparam int         CS_DFC     = 2;
	localparam int         CS_CL1     = 1;
	localparam int         CS_CL0     = 0;
	localparam logic [3:0] CLKSEL_RST = 4'h0;

	// expansion register fields
	localparam int FEXP_CLX = 0;
	localparam int CEXP_HI  = 1;
	localparam int CEXP_LO  = 0;

	// interrupt status and mask layout
	localparam int IRQ_SPD = 0;
	localparam int IRQ_STD = 1;
	localparam int IRQ_ACK = 2;
	localparam int IRQ_W   = 3;

	// =====================================================
	// byte tracking
	localparam logic [3:0] BIT_IDLE  = 4'h0;
	localparam logic [3:0] BIT_EIGHT = 4'h8;
	localparam logic [3:0] BIT_NINTH = 4'h9;

	// =====================================================
	// selection clock divisors
	localparam logic [7:0] DIV_12  = 8'h0C;
	localparam logic [7:0] DIV_24  = 8'h18;
	localparam logic [7:0] DIV_48  = 8'h30;
	localparam logic [7:0] DIV_36  = 8'h24;
	localparam logic [7:0] DIV_54  = 8'h36;
	localparam logic [7:0] DIV_44  = 8'h2C;
	localparam logic [7:0] DIV_86  = 8'h56;
	localparam logic [7:0] DIV_172 = 8'hAC;
	localparam logic [7:0] DIV_132 = 8'h84;
	localparam logic [7:0] DIV_198 = 8'hC6;
	localparam logic [7:0] DIV_T18 = 8'h12;
	localparam logic [7:0] DIV_T66 = 8'h42;

	// noise filter: samples that must agree before a line level moves
	localparam int FILT_LEN = 3;
endpackage

// *** rtl/isc_line_filter.sv ***
// synchroniser and optional digital noise filter for the two bus lines
`timescale 1ns/100ps
`default_nettype none
module isc_line_filter (
	input  wire logic mclk_in,
	input  wire logic arst_n_in,
	input  wire logic filt_en_in,
	input  wire logic scl_raw_in,
	input  wire logic sda_raw_in,
	output var  logic scl_out,
	output var  logic sda_out
);
	import isc_pkg::*;

	logic [1:0] raw;
	wire  [1:0] clean;

	assign raw = {scl_raw_in, sda_raw_in};
	assign scl_out = clean[1];
	assign sda_out = clean[0];

	// =====================================================
	// one synchroniser and filter per line
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_line
			logic                meta;
			logic                sync;
			logic [FILT_LEN-1:0] hist;
			logic                level;

			// each line owns its own flop, joined onto the shared vector here
			assign clean[g] = level;

			// two-flop synchroniser; meta feeds only sync
			always_ff @(posedge mclk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					meta <= 1'b1;
					sync <= 1'b1;
				end else begin
					meta <= raw[g];
					sync <= meta;
				end
			end

			// history of synchronised samples, level moves on full agreement
			always_ff @(posedge mclk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					hist  <= '1;
					level <= 1'b1;
				end else begin
					hist <= {hist[FILT_LEN-2:0], sync};
					if (!filt_en_in)
						level <= sync;
					else if (&hist)
						level <= 1'b1;
					else if (~|hist)
						level <= 1'b0;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// *** verification/isc_i2c_master_model.sv ***
// behavioural i2c master that drives the open-drain lines around the block
`timescale 1ns/100ps
`default_nettype none
module isc_i2c_master_model #(
	parameter int H = 8
) (
	input  wire logic mclk_in,
	input  wire logic scl_line_in,
	output var  logic scl_low_out,
	output var  logic sda_low_out,
	output var  logic stuck_out
);
	// =====================================================
	// lines released at time zero, so the pull-ups read high
	initial begin
		scl_low_out = 1'b0;
		sda_low_out = 1'b0;
		stuck_out   = 1'b0;
	end

	// one third of a serial clock period; the clock is high for one and low for two
	task automatic pause();
		repeat (H) @(posedge mclk_in);
	endtask

	// data falls while the clock is high, then the clock goes low
	task automatic start();
		sda_low_out <= 1'b1;
		pause();
		scl_low_out <= 1'b1;
		pause();
	endtask

	// one clock with data set up first; waits while the device stretches
	task automatic bit_out(input logic b);
		int n;
		sda_low_out <= !b;
		pause();
		scl_low_out <= 1'b0;
		n = 0;
		while (scl_line_in !== 1'b1 && n < 1000) begin
			@(posedge mclk_in);
			n++;
		end
		if (n >= 1000) begin
			stuck_out <= 1'b1;
		end
		pause();
		scl_low_out <= 1'b1;
		pause();
	endtask

	// eight data bits msb first, then the acknowledge bit
	task automatic send_byte(input logic [7:0] d, input logic ack_bit);
		for (int i = 7; i >= 0; i--) begin
			bit_out(d[i]);
		end
		bit_out(ack_bit);
	endtask

	// data rises while the clock is high
	task automatic stop();
		sda_low_out <= 1'b1;
		pause();
		scl_low_out <= 1'b0;
		pause();
		sda_low_out <= 1'b0;
		pause();
	endtask
endmodule
`default_nettype wire

// *** verification/tb_i2c_status_and_clock_select.sv ***
// self-checking bench of the status flags and transfer clock select block
`timescale 1ns/100ps
`default_nettype none
module tb_i2c_status_and_clock_select;
	import isc_pkg::*;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [31:0] rd; logic hs; int per;} isc_row_s;
	logic        mclk, arst_n, psel, penable, pwrite, pready, pslverr, err_q, tmr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd_q, p;
	logic [3:0]  pstrb;
	logic        scl_oe, sda_oe, sel_tick, hs_mode, irq, scl_w, sda_w, m_scl, m_sda, stuck, scl_o, sda_o;
	int          fails, checks;
	isc_row_s    rows [10];

	// =====================================================
	// open-drain lines with pull-ups
	assign scl_w = !(m_scl || scl_oe);
	assign sda_w = !(m_sda || sda_oe);

	isc_i2c_status_clksel uut (.mclk_in(mclk), .arst_n_in(arst_n), .paddr_in(paddr), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .pstrb_in(pstrb),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .scl_in(scl_w),
		.scl_out(scl_o), .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe),
		.timer_tick_in(tmr), .sel_tick_out(sel_tick), .hs_mode_out(hs_mode), .irq_out(irq));
	isc_i2c_master_model m (.mclk_in(mclk), .scl_line_in(scl_w), .scl_low_out(m_scl),
		.sda_low_out(m_sda), .stuck_out(stuck));

	// clock
	always #5 mclk = ~mclk;

	// timer pulse on every second cycle, so a timer divisor of n gives 2n cycles
	always @(posedge mclk) tmr <= ~tmr;

	task automatic complete_run();
		if (fails == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// one apb transfer: setup, access until pready
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			fails++;
			complete_run();
		end
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0);
		chk(rd_q, exp);
	endtask

	// period between selection clock ticks, past any irregular first one
	task automatic per();
		int n;
		for (int k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(posedge mclk);
				n++;
			end while (sel_tick !== 1'b1 && n < 400);
		end
		if (n >= 400) begin
			fails++;
			complete_run();
		end
		p = n;
	endtask

	// =====================================================
	// register rows: write, then clock select readback, mode and divisor
	initial begin
		rows[0] = '{ADDR_CLKSEL, 8'h3F, 32'h0F, 1'b1, 36};
		rows[1] = '{ADDR_CLKSEL_CLR, 8'h0F, 32'h00, 1'b0, 44};
		rows[2] = '{ADDR_CLKSEL_SET, 8'h01, 32'h01, 1'b0, 86};
		rows[3] = '{ADDR_CLKSEL, 8'h02, 32'h02, 1'b0, 172};
		rows[4] = '{ADDR_CLKSEL, 8'h03, 32'h03, 1'b0, 132};
		rows[5] = '{ADDR_CEXP, 8'h02, 32'h03, 1'b0, 198};
		rows[6] = '{ADDR_CLKSEL, 8'h08, 32'h08, 1'b1, 24};
		rows[7] = '{ADDR_CLKSEL, 8'h0C, 32'h0C, 1'b1, 24};
		rows[8] = '{ADDR_FEXP, 8'h01, 32'h0C, 1'b1, 12};
		rows[9] = '{ADDR_CTRL, 8'h80, 32'h3C, 1'b1, 12};
		{mclk, tmr, arst_n, psel, penable, pwrite, paddr, pwdata, fails, checks} = '0;
		pstrb = 4'hF;
		cyc(12);
		arst_n <= 1'b1;
		cyc(1);
		rdchk(ADDR_CLKSEL, 32'h0);
		rdchk(ADDR_STATUS, 32'h0);
		foreach (rows[i]) begin
			apb(rows[i].a, 1'b1, {24'h0, rows[i].d});
			rdchk(ADDR_CLKSEL, rows[i].rd);
			chk({31'h0, hs_mode}, {31'h0, rows[i].hs});
			if (rows[i].per != 0) begin
				per();
				chk(p, rows[i].per);
			end
		end
		apb(8'h40, 1'b0, 32'h0);
		chk({31'h0, err_q}, 32'h1);
		chk(rd_q, 32'h0);
		apb(ADDR_CLKSEL, 1'b1, 32'h0);
		apb(ADDR_FEXP, 1'b1, 32'h0);
		// address byte with acknowledge, wait and transmit state
		m.start();
		rdchk(ADDR_CLKSEL, 32'h0);
		rdchk(ADDR_STATUS, 32'h2);
		chk({31'h0, irq}, 32'h0);
		rdchk(ADDR_IRQ_STAT, 32'h2);
		apb(ADDR_IRQ_MASK, 1'b1, 32'h7);
		cyc(3);
		chk({31'h0, irq}, 32'h1);
		apb(ADDR_IRQ_STAT, 1'b1, 32'h7);
		cyc(3);
		chk({31'h0, irq}, 32'h0);
		m.send_byte(8'hA0, 1'b0);
		chk({31'h0, scl_oe}, 32'h1);
		rdchk(ADDR_STATUS, 32'h6);
		apb(ADDR_CTRL, 1'b1, 32'h89);
		rdchk(ADDR_STATUS, 32'hE);
		chk({31'h0, sda_oe}, 32'h1);
		apb(ADDR_CTRL, 1'b1, 32'hA1);
		cyc(2);
		chk({30'h0, scl_oe, sda_oe}, 32'h0);
		rdchk(ADDR_STATUS, 32'h6);
		m.bit_out(1'b1);
		rdchk(ADDR_STATUS, 32'h0);
		m.stop();
		rdchk(ADDR_STATUS, 32'h1);
		m.start();
		rdchk(ADDR_STATUS, 32'h3);
		m.bit_out(1'b0);
		rdchk(ADDR_STATUS, 32'h2);
		apb(ADDR_CTRL, 1'b1, 32'hC0);
		rdchk(ADDR_STATUS, 32'h0);
		m.stop();
		rdchk(ADDR_STATUS, 32'h1);
		apb(ADDR_CTRL, 1'b1, 32'h0);
		rdchk(ADDR_STATUS, 32'h0);
		rdchk(ADDR_CLKSEL, 32'h0);
		// reset in mid-run
		apb(ADDR_CLKSEL, 1'b1, 32'h0F);
		arst_n <= 1'b0;
		cyc(2);
		arst_n <= 1'b1;
		cyc(1);
		rdchk(ADDR_CLKSEL, 32'h0);
		chk({31'h0, stuck}, 32'h0);
		chk({30'h0, scl_o, sda_o}, 32'h0);
		complete_run();
	end
endmodule
`default_nettype wire
